//--- rtl/adcfr_top.sv
// Converter function register bank with shadowing and test patterns.
// Assumes the serial port is decoded upstream into one request per cycle.
// Contract
// [RULE1] Commit bit copies every pending shadow setting to active at once.
// [RULE2] Shadowed writes do nothing until commit; commit bit self-clears.
// [RULE3] Local writes hit every enabled channel; read one channel at a time.
// [RULE4] Pin function bit: 0 pin gives full power-down, 1 gives standby.
// [RULE5] Per-channel power mode defaults to 00, meaning normal operation.
// [RULE6] Divide ratio field divides input clock by value plus one.
// [RULE7] Shuffle field 00 disables shuffle; reset value leaves it enabled.
// [RULE8] Nonzero test code replaces samples with pattern; 000 is normal.
// [RULE9] Codes 001, 010, 011 give midscale, plus and minus full scale.
// [RULE10] Code 100 gives checkerboard, 111 toggles all ones and zeros.
// [RULE11] Code 101 gives long noise sequence, 110 the short one.
// [RULE12] Long noise reset bit 0 holds generator, 1 lets it run.
// [RULE13] Short noise reset bit 0 holds generator, 1 lets it run.
// [RULE14] Self-test enable bit 1 starts the channel self-test.
// [RULE15] Self-test reset bit 0 holds self-test logic in reset.
`timescale 1ns/10ps
`default_nettype none
module adcfr_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register access
  input wire adcfr_pkg::adcfr_req_t req,
  output logic [7:0] rdata,
  output logic rd_valid,
  // Power-down pin and power state
  input wire logic pdwn_pin,
  output logic full_pd,
  output logic standby,
  output logic [adcfr_pkg::NCH-1:0][1:0] chan_pmode,
  output logic [adcfr_pkg::NCH-1:0] shuffle_en,
  // Sample path
  input wire logic [adcfr_pkg::NCH-1:0][adcfr_pkg::DW-1:0] sample_in,
  output logic sample_en,
  output logic [adcfr_pkg::NCH-1:0][adcfr_pkg::DW-1:0] dout,
  // Self-test
  output logic [adcfr_pkg::NCH-1:0] built_in_self_test_running,
  output logic [adcfr_pkg::NCH-1:0] built_in_self_test_done
);
  localparam int NCH = adcfr_pkg::NCH;

  // ==========================================================
  // Register file
  logic [7:0] chan_idx, next_chan_idx;
  logic commit, next_commit;
  logic pinfn_sh, next_pinfn_sh;
  logic [2:0] div_sh, next_div_sh;
  adcfr_pkg::adcfr_lcl_t [NCH-1:0] lcl_sh, next_lcl_sh;
  logic [7:0] next_rdata;
  adcfr_pkg::adcfr_lcl_t rl;
  int rc;

  always_comb begin
    next_chan_idx = chan_idx;
    next_pinfn_sh = pinfn_sh;
    next_div_sh = div_sh;
    next_lcl_sh = lcl_sh;
    next_commit = 1'b0; // see [RULE2]
    if (req.wr) begin
      case (req.addr)
        adcfr_pkg::A_CHAN: next_chan_idx = req.wdata;
        adcfr_pkg::A_COMMIT:
          next_commit = req.wdata[adcfr_pkg::B_COMMIT]; // see [RULE1]
        adcfr_pkg::A_PWR: next_pinfn_sh = req.wdata[adcfr_pkg::B_PINFN];
        adcfr_pkg::A_DIV: next_div_sh = req.wdata[2:0];
        default: ;
      endcase
      for (int c = 0; c < NCH; c++) begin
        if (chan_idx[c]) begin // see [RULE3]
          case (req.addr)
            adcfr_pkg::A_PWR: next_lcl_sh[c].pmode = req.wdata[1:0];
            adcfr_pkg::A_SHUF: next_lcl_sh[c].shuf = req.wdata[1:0];
            adcfr_pkg::A_TEST:
              next_lcl_sh[c].test = req.wdata & adcfr_pkg::M_TEST;
            adcfr_pkg::A_BUILT_IN_SELF_TEST:
              next_lcl_sh[c].built_in_self_test = req.wdata & adcfr_pkg::M_BUILT_IN_SELF_TEST;
            default: ;
          endcase
        end
      end
    end
    // Several channels selected: channel A answers
    rc = chan_idx[0] ? 0 : 1; // see [RULE3]
    rl = lcl_sh[rc];
    case (req.addr)
      adcfr_pkg::A_CHAN: next_rdata = chan_idx;
      adcfr_pkg::A_COMMIT: next_rdata = {7'h00, commit};
      adcfr_pkg::A_PWR: next_rdata = {2'h0, pinfn_sh, 3'h0, rl.pmode};
      adcfr_pkg::A_DIV: next_rdata = {5'h00, div_sh};
      adcfr_pkg::A_SHUF: next_rdata = {6'h00, rl.shuf};
      adcfr_pkg::A_TEST: next_rdata = rl.test;
      adcfr_pkg::A_BUILT_IN_SELF_TEST: next_rdata = rl.built_in_self_test;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chan_idx <= adcfr_pkg::R_CHAN;
      commit <= 1'b0;
      pinfn_sh <= adcfr_pkg::R_PINFN;
      div_sh <= adcfr_pkg::R_DIV;
      for (int c = 0; c < NCH; c++) begin
        lcl_sh[c] <= {adcfr_pkg::R_PMODE, adcfr_pkg::R_SHUF,
                      adcfr_pkg::R_TEST, adcfr_pkg::R_BUILT_IN_SELF_TEST};
      end
      rdata <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      chan_idx <= next_chan_idx;
      commit <= next_commit;
      pinfn_sh <= next_pinfn_sh;
      div_sh <= next_div_sh;
      lcl_sh <= next_lcl_sh;
      rdata <= next_rdata;
      rd_valid <= req.rd;
    end
  end

  // ==========================================================
  // Active settings, loaded only by a commit
  logic pinfn, next_pinfn;
  logic [2:0] div, next_div;
  adcfr_pkg::adcfr_lcl_t [NCH-1:0] lcl, next_lcl;
  logic next_full_pd, next_standby;
  logic [NCH-1:0][1:0] next_chan_pmode;
  logic [NCH-1:0] next_shuffle_en;

  always_comb begin
    next_pinfn = pinfn;
    next_div = div;
    next_lcl = lcl;
    if (commit) begin // see [RULE1]
      next_pinfn = pinfn_sh;
      next_div = div_sh;
      next_lcl = lcl_sh;
    end
    next_full_pd = pdwn_pin & ~pinfn; // see [RULE4]
    next_standby = pdwn_pin & pinfn;
    for (int c = 0; c < NCH; c++) begin
      next_chan_pmode[c] = lcl[c].pmode; // see [RULE5]
      next_shuffle_en[c] = |lcl[c].shuf; // see [RULE7]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pinfn <= adcfr_pkg::R_PINFN;
      div <= adcfr_pkg::R_DIV; // see [RULE6]
      for (int c = 0; c < NCH; c++) begin
        lcl[c] <= {adcfr_pkg::R_PMODE, adcfr_pkg::R_SHUF,
                   adcfr_pkg::R_TEST, adcfr_pkg::R_BUILT_IN_SELF_TEST};
      end
      full_pd <= 1'b0;
      standby <= 1'b0;
      chan_pmode <= '0;
      shuffle_en <= '0;
    end else begin
      pinfn <= next_pinfn;
      div <= next_div;
      lcl <= next_lcl;
      full_pd <= next_full_pd;
      standby <= next_standby;
      chan_pmode <= next_chan_pmode;
      shuffle_en <= next_shuffle_en;
    end
  end

  // ==========================================================
  // Input clock divider
  logic [2:0] dcnt, next_dcnt;
  logic next_sample_en;

  always_comb begin
    // Compare with >= so a smaller ratio never strands the count
    next_sample_en = (dcnt >= div); // see [RULE6]
    next_dcnt = next_sample_en ? 3'h0 : dcnt + 3'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dcnt <= 3'h0;
      sample_en <= 1'b0;
    end else begin
      dcnt <= next_dcnt;
      sample_en <= next_sample_en;
    end
  end

  // ==========================================================
  // Per-channel pattern generators and self-test
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [22:0] pnl, next_pnl;
    logic [8:0] pns, next_pns;
    logic tog, next_tog;
    logic [7:0] bcnt, next_bcnt;
    logic [10:0] next_dout;
    logic brun, next_bdone;
    logic [2:0] code;

    always_comb begin
      code = lcl[g].test[2:0];
      next_pnl = pnl;
      next_pns = pns;
      next_tog = tog;
      next_dout = dout[g];
      if (sample_en) begin
        next_pnl = {pnl[21:0], pnl[22] ^ pnl[17]};
        next_pns = {pns[7:0], pns[8] ^ pns[4]};
        next_tog = ~tog;
        case (code) // see [RULE8]
          adcfr_pkg::T_OFF: next_dout = sample_in[g];
          adcfr_pkg::T_MID: next_dout = adcfr_pkg::P_MID; // see [RULE9]
          adcfr_pkg::T_PFS: next_dout = adcfr_pkg::P_PFS;
          adcfr_pkg::T_NFS: next_dout = adcfr_pkg::P_NFS;
          adcfr_pkg::T_CHK: // see [RULE10]
            next_dout = tog ? ~adcfr_pkg::P_CHK : adcfr_pkg::P_CHK;
          adcfr_pkg::T_PNL: next_dout = pnl[10:0]; // see [RULE11]
          adcfr_pkg::T_PNS: next_dout = {pns[1:0], pns};
          adcfr_pkg::T_TOG:
            next_dout = tog ? adcfr_pkg::P_NFS : adcfr_pkg::P_PFS;
          default: next_dout = sample_in[g];
        endcase
      end
      // Reset bit low holds the generator at its seed
      if (!lcl[g].test[adcfr_pkg::B_LRST]) begin // see [RULE12]
        next_pnl = adcfr_pkg::SEED_L;
      end
      if (!lcl[g].test[adcfr_pkg::B_SRST]) begin // see [RULE13]
        next_pns = adcfr_pkg::SEED_S;
      end
      brun = lcl[g].built_in_self_test[adcfr_pkg::B_BEN] &
             lcl[g].built_in_self_test[adcfr_pkg::B_BRST]; // see [RULE14] [RULE15]
      next_bcnt = bcnt;
      if (!brun) begin
        next_bcnt = 8'h00;
      end else if (sample_en && bcnt != adcfr_pkg::BUILT_IN_SELF_TEST_LEN) begin
        next_bcnt = bcnt + 8'h01;
      end
      next_bdone = brun && (bcnt == adcfr_pkg::BUILT_IN_SELF_TEST_LEN);
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        pnl <= adcfr_pkg::SEED_L;
        pns <= adcfr_pkg::SEED_S;
        tog <= 1'b0;
        bcnt <= 8'h00;
        dout[g] <= 11'h000;
        built_in_self_test_running[g] <= 1'b0;
        built_in_self_test_done[g] <= 1'b0;
      end else begin
        pnl <= next_pnl;
        pns <= next_pns;
        tog <= next_tog;
        bcnt <= next_bcnt;
        dout[g] <= next_dout;
        built_in_self_test_running[g] <= brun;
        built_in_self_test_done[g] <= next_bdone;
      end
    end

    chk_test_mid: assert property (@(posedge clk_sys) // see [RULE9]
      disable iff (!rst_n)
      sample_en && code == adcfr_pkg::T_MID |=> dout[g] == adcfr_pkg::P_MID)
      else $error("midscale pattern wrong");
    // Previous word must come from a toggle sample, not another pattern
    chk_word_toggle: assert property (@(posedge clk_sys) // see [RULE10]
      disable iff (!rst_n)
      sample_en && $past(sample_en) && code == adcfr_pkg::T_TOG &&
      $past(code) == adcfr_pkg::T_TOG && dout[g] == adcfr_pkg::P_PFS
      |=> dout[g] == adcfr_pkg::P_NFS)
      else $error("word toggle did not flip");
    chk_long_hold: assert property (@(posedge clk_sys) // see [RULE12]
      disable iff (!rst_n)
      !lcl[g].test[adcfr_pkg::B_LRST] |=> pnl == adcfr_pkg::SEED_L)
      else $error("long generator ran in reset");
    chk_built_in_self_test_gate: assert property (@(posedge clk_sys) // see [RULE15]
      disable iff (!rst_n)
      !lcl[g].built_in_self_test[adcfr_pkg::B_BRST] |=> !built_in_self_test_running[g])
      else $error("self-test ran while held");
    cov_pn_long: cover property (@(posedge clk_sys)
      sample_en && code == adcfr_pkg::T_PNL);
    cov_built_in_self_test_done: cover property (@(posedge clk_sys) built_in_self_test_done[g]);
  end

  // ==========================================================
  // Checks
  chk_commit_copy: assert property (@(posedge clk_sys) // see [RULE1]
    disable iff (!rst_n)
    commit |=> div == $past(div_sh) && lcl == $past(lcl_sh))
    else $error("commit did not copy shadow");
  chk_commit_clear: assert property (@(posedge clk_sys) // see [RULE2]
    disable iff (!rst_n)
    commit && !(req.wr && req.addr == adcfr_pkg::A_COMMIT) |=> !commit)
    else $error("commit bit stuck");
  chk_shadow_hold: assert property (@(posedge clk_sys) // see [RULE2]
    disable iff (!rst_n)
    !commit |=> $stable(div) && $stable(lcl) && $stable(pinfn))
    else $error("active changed without commit");
  chk_index_write: assert property (@(posedge clk_sys) // see [RULE3]
    disable iff (!rst_n)
    req.wr && req.addr == adcfr_pkg::A_SHUF && chan_idx[1]
    |=> lcl_sh[1].shuf == $past(req.wdata[1:0]))
    else $error("local write missed channel");
  chk_pin_full: assert property (@(posedge clk_sys) // see [RULE4]
    disable iff (!rst_n)
    pdwn_pin && !pinfn |=> full_pd && !standby)
    else $error("pin did not give full power-down");
  chk_pin_standby: assert property (@(posedge clk_sys) // see [RULE4]
    disable iff (!rst_n)
    pdwn_pin && pinfn |=> standby && !full_pd)
    else $error("pin did not give standby");
  // Looks back so a later commit of a new ratio cannot trip it
  chk_div_four: assert property (@(posedge clk_sys) // see [RULE6]
    disable iff (!rst_n)
    $past(sample_en, 4) && $past(div, 1) == 3'h3 && $past(div, 2) == 3'h3
    && $past(div, 3) == 3'h3 && $past(div, 4) == 3'h3
    |-> sample_en && !$past(sample_en, 1) && !$past(sample_en, 2)
    && !$past(sample_en, 3))
    else $error("divide by four period wrong");
  chk_reset_mode: assert property (@(posedge clk_sys) // see [RULE5]
    !rst_n |=> lcl[0].pmode == 2'h0 && lcl[0].shuf == 2'h1)
    else $error("power or shuffle reset value wrong");
  cov_commit: cover property (@(posedge clk_sys) commit);
  cov_standby: cover property (@(posedge clk_sys) standby);
endmodule
`default_nettype wire

//--- common/adcfr_pkg.sv
// Constants and carrier types for the converter function registers.
// Assumes one 8-bit register access port and two converter channels.
package adcfr_pkg;
  localparam int NCH = 2;
  localparam int DW = 11;
  // Offsets
  localparam logic [7:0] A_CHAN = 8'h05;
  localparam logic [7:0] A_PWR = 8'h08;
  localparam logic [7:0] A_DIV = 8'h0b;
  localparam logic [7:0] A_SHUF = 8'h0c;
  localparam logic [7:0] A_TEST = 8'h0d;
  localparam logic [7:0] A_BUILT_IN_SELF_TEST = 8'h0e;
  localparam logic [7:0] A_COMMIT = 8'hff;
  // Values after reset
  localparam logic [7:0] R_CHAN = 8'hcf;
  localparam logic [1:0] R_PMODE = 2'h0;
  localparam logic R_PINFN = 1'b0;
  localparam logic [2:0] R_DIV = 3'h0;
  localparam logic [1:0] R_SHUF = 2'h1;
  localparam logic [7:0] R_TEST = 8'h30;
  localparam logic [7:0] R_BUILT_IN_SELF_TEST = 8'h04;
  // Field positions and masks
  localparam int B_PINFN = 5;
  localparam int B_LRST = 5;
  localparam int B_SRST = 4;
  localparam int B_BRST = 2;
  localparam int B_BEN = 0;
  localparam int B_COMMIT = 0;
  localparam logic [7:0] M_TEST = 8'h37;
  localparam logic [7:0] M_BUILT_IN_SELF_TEST = 8'h05;
  // Output test codes
  localparam logic [2:0] T_OFF = 3'h0;
  localparam logic [2:0] T_MID = 3'h1;
  localparam logic [2:0] T_PFS = 3'h2;
  localparam logic [2:0] T_NFS = 3'h3;
  localparam logic [2:0] T_CHK = 3'h4;
  localparam logic [2:0] T_PNL = 3'h5;
  localparam logic [2:0] T_PNS = 3'h6;
  localparam logic [2:0] T_TOG = 3'h7;
  // Pattern words, offset binary
  localparam logic [10:0] P_MID = 11'h400;
  localparam logic [10:0] P_PFS = 11'h7ff;
  localparam logic [10:0] P_NFS = 11'h000;
  localparam logic [10:0] P_CHK = 11'h555;
  localparam logic [22:0] SEED_L = 23'h7fffff;
  localparam logic [8:0] SEED_S = 9'h1ff;
  localparam logic [7:0] BUILT_IN_SELF_TEST_LEN = 8'hff;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcfr_req_t;
  typedef struct packed {
    logic [1:0] pmode;
    logic [1:0] shuf;
    logic [7:0] test;
    logic [7:0] built_in_self_test;
  } adcfr_lcl_t;
endpackage

//--- verification/adcfr_host.sv
// Host controller model driving the register request port.
// Assumes one request per clock, taken on the rising edge after it is set.
`timescale 1ns/10ps
`default_nettype none
module adcfr_host (
  // Clock
  input wire logic clk_sys,
  // Register access
  output var adcfr_pkg::adcfr_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  initial req = '0;
  // ==========================================================
  // Bus cycles
  // Idle lines show inverted data so a stale value cannot match
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    #1;
    d = rdata;
    v = rd_valid;
  endtask
  task automatic commit();
    put(adcfr_pkg::A_COMMIT, 8'h01);
  endtask
  // Single channel selected before any local read
  task automatic get_lcl(input logic [7:0] ch, input logic [7:0] a,
                         output logic [7:0] d, output logic v);
    put(adcfr_pkg::A_CHAN, ch);
    get(a, d, v);
  endtask
endmodule
`default_nettype wire

//--- verification/adc_function_control_regs_bench.sv
// Self-checking bench for the converter function register bank.
// Assumes the host model above and div 0 before pattern checks.
`timescale 1ns/10ps
`default_nettype none
module adc_function_control_regs_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic pdwn_pin = 1'b0;
  logic [1:0][10:0] sample_in = '0;
  adcfr_pkg::adcfr_req_t req;
  logic [7:0] rdata;
  logic rd_valid, full_pd, standby, sample_en;
  logic [1:0][1:0] chan_pmode;
  logic [1:0] shuffle_en, built_in_self_test_running, built_in_self_test_done;
  logic [1:0][10:0] dout, d1, d2;
  int failures = 0;
  int num_checks = 0;
  int n;
  logic [2:0] code;
  logic [10:0] e;
  always #20 clk_sys = ~clk_sys;
  adcfr_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
    .rdata(rdata), .rd_valid(rd_valid), .pdwn_pin(pdwn_pin),
    .full_pd(full_pd), .standby(standby), .chan_pmode(chan_pmode),
    .shuffle_en(shuffle_en), .sample_in(sample_in),
    .sample_en(sample_en), .dout(dout), .built_in_self_test_running(built_in_self_test_running),
    .built_in_self_test_done(built_in_self_test_done));
  adcfr_host host (.clk_sys(clk_sys), .req(req), .rdata(rdata),
    .rd_valid(rd_valid));
  // ==========================================================
  // Checks and helpers
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_out(input logic [21:0] got, input logic [21:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: output %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.get(a, d, v);
    cmp_reg(d, exp);
    cmp_reg({7'h0, v}, 8'h01);
  endtask
  task automatic rdl(input logic [7:0] ch, a, exp);
    logic [7:0] d;
    logic v;
    host.get_lcl(ch, a, d, v);
    cmp_reg(d, exp);
  endtask
  task automatic set(input logic [7:0] a, input logic [7:0] d);
    host.put(a, d);
    host.commit();
    go(4);
  endtask
  task automatic two();
    d1 = dout;
    go(1);
    d2 = dout;
  endtask
  function automatic logic [10:0] fixed_word(input logic [2:0] c);
    case (c)
      3'h1: return adcfr_pkg::P_MID;
      3'h2: return adcfr_pkg::P_PFS;
      default: return adcfr_pkg::P_NFS;
    endcase
  endfunction
  task automatic close_out();
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    failures++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hd5a8));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    go(2);
    cmp_out({20'h0, chan_pmode}, 22'h0);
    cmp_out({20'h0, shuffle_en}, 22'h3);
    rd(adcfr_pkg::A_CHAN, 8'hcf);
    rd(adcfr_pkg::A_DIV, 8'h00);
    rd(adcfr_pkg::A_COMMIT, 8'h00);
    rd(8'h20, 8'h00);
    rdl(8'h01, adcfr_pkg::A_PWR, 8'h00);
    rdl(8'h02, adcfr_pkg::A_SHUF, 8'h01);
    rdl(8'h01, adcfr_pkg::A_TEST, 8'h30);
    rdl(8'h02, adcfr_pkg::A_BUILT_IN_SELF_TEST, 8'h04);
    // Shadowed write held back until commit
    host.put(adcfr_pkg::A_CHAN, 8'h03);
    host.put(adcfr_pkg::A_SHUF, 8'h00);
    go(4);
    cmp_out({20'h0, shuffle_en}, 22'h3);
    host.commit();
    go(4);
    cmp_out({20'h0, shuffle_en}, 22'h0);
    rd(adcfr_pkg::A_COMMIT, 8'h00);
    // Channel steering of local writes
    host.put(adcfr_pkg::A_CHAN, 8'h01);
    host.put(adcfr_pkg::A_SHUF, 8'h01);
    host.put(adcfr_pkg::A_PWR, 8'h02);
    rdl(8'h02, adcfr_pkg::A_SHUF, 8'h00);
    host.commit();
    go(4);
    cmp_out({18'h0, chan_pmode, shuffle_en}, 22'h9);
    // Power-down pin function
    host.put(adcfr_pkg::A_CHAN, 8'h03);
    set(adcfr_pkg::A_PWR, 8'h00);
    @(posedge clk_sys);
    pdwn_pin <= 1'b1;
    go(2);
    cmp_out({20'h0, full_pd, standby}, 22'h2);
    set(adcfr_pkg::A_PWR, 8'h20);
    cmp_out({20'h0, full_pd, standby}, 22'h1);
    @(posedge clk_sys);
    pdwn_pin <= 1'b0;
    // Divider, both end codes and random ones
    for (int k = 0; k < 5; k++) begin
      code = (k == 0) ? 3'h7 : (k == 1) ? 3'h3 :
             (k == 4) ? 3'h0 : 3'($urandom_range(1, 6));
      set(adcfr_pkg::A_DIV, {5'h0, code});
      for (n = 0; n < 20 && sample_en !== 1'b1; n++) go(1);
      n = 0;
      do begin
        go(1);
        n++;
      end while (n < 20 && sample_en !== 1'b1);
      cmp_out(22'(n), 22'(code) + 22'h1);
    end
    // Fixed and alternating patterns, normal samples at code 0
    for (int i = 0; i < 6; i++) begin
      code = (i == 5) ? 3'h7 : 3'(i);
      set(adcfr_pkg::A_TEST, {5'h6, code});
      @(posedge clk_sys);
      sample_in <= {11'($urandom), 11'($urandom)};
      go(3);
      two();
      e = fixed_word(code);
      if (code == 3'h0) cmp_out(d1, sample_in);
      else if (code < 3'h4) cmp_out(d1, {e, e});
      else cmp_out(d1 ^ d2, {2{11'h7ff}});
      e = (code == 3'h4) ? adcfr_pkg::P_CHK : adcfr_pkg::P_PFS;
      n = int'(d1[0] === e || d2[0] === e);
      if (code >= 3'h4) cmp_out(22'(n), 22'h1);
    end
    // Noise generators held and released
    for (int k = 0; k < 4; k++) begin
      set(adcfr_pkg::A_TEST, (k < 2) ? 8'(5 + k) : 8'(8'h30 + 5 + k - 2));
      two();
      if (k < 2) cmp_out(d1 & d2, {2{11'h7ff}});
      else cmp_out({21'h0, d1 !== d2}, 22'h1);
    end
    // Self-test start, completion and hold in reset
    set(adcfr_pkg::A_BUILT_IN_SELF_TEST, 8'h05);
    cmp_out({20'h0, built_in_self_test_running}, 22'h3);
    for (n = 0; n < 300 && built_in_self_test_done !== 2'h3; n++) go(1);
    cmp_out({20'h0, built_in_self_test_done}, 22'h3);
    set(adcfr_pkg::A_BUILT_IN_SELF_TEST, 8'h01);
    cmp_out({18'h0, built_in_self_test_running, built_in_self_test_done}, 22'h0);
    close_out();
  end
endmodule
`default_nettype wire
